// [hdl/uartm_core.sv]
// Asynchronous serial port with muting, parity, 16x oversampling and one shared interrupt.
`timescale 1ns/1ps

module uartm_core (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Serial line.
	input  wire logic        rx_pin,
	output logic             tx_pin,
	// Processor state and interrupt.
	input  wire logic        global_irq_mask,
	input  wire logic        wait_mode,
	input  wire logic        halt_mode,
	output logic             irq,
	output logic             wait_wake
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.

	uartm_pkg::uartm_cr1_t      cr1_q;        // Control register one.
	uartm_pkg::uartm_cr2_t      cr2_q;        // Control register two.
	uartm_pkg::uartm_rxflags_t  rxf_q;        // Receive status flags.
	uartm_pkg::uartm_rx_state_t rx_st_q;      // Receiver state.
	logic [15:0] baud_q;                      // Sample tick divisor minus one.
	logic        ovr_en_q;                    // Separate overrun interrupt enable.
	logic [15:0] bdiv_q;                      // Sample tick divider.
	logic        tick;                        // One sample tick, 16 per bit.
	logic        run;                         // Low while halted.
	logic [1:0]  rx_sync_q;                   // Line synchroniser.
	logic        rxs;                         // Synchronised line level.
	logic [2:0]  hist_q;                      // Last three line samples.
	logic [4:0]  scnt_q;                      // Sample number in current bit.
	logic [4:0]  snext;                       // Number of the sample now taken.
	logic [2:0]  maj_q;                       // Samples 8, 9 and 10.
	logic [3:0]  bidx_q;                      // Received bit index.
	logic [8:0]  rxw_q;                       // Received word.
	logic        npend_q;                     // Noise seen since last frame.
	logic [7:0]  rdr_q;                       // Receive data buffer.
	logic [7:0]  idle_cnt_q;                  // Ones samples seen while hunting.
	logic        idle_arm_q;                  // Idle may be reported again.
	logic        frame_done;                  // Frame finished on this tick.
	logic        bit_val;                     // Majority of the current bit.
	logic        bit_noisy;                   // Middle samples disagree.
	logic        idle_hit;                    // Idle frame recognised.
	logic [7:0]  tdr_q;                       // Transmit data buffer.
	logic        tdr_full_q;                  // Transmit buffer holds a byte.
	logic        tc_q;                        // Transmission complete.
	logic        tx_busy_q;                   // Shifter active.
	logic [10:0] tsh_q;                       // Transmit shifter.
	logic [3:0]  tbits_q;                     // Bits left to send.
	logic [3:0]  tdiv_q;                      // Ticks inside a transmit bit.
	logic        st_seen_q;                   // Status register was accessed.
	logic        apb_do;                      // Transfer completes now.
	logic        wr_data;                     // Data register write completes.
	logic        rd_data;                     // Data register read completes.
	logic        irq_d;                       // Next interrupt request.

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Majority of three samples.
	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// Parity bit over the seven or eight low bits for the chosen sense.
	function automatic logic par_calc(input logic [8:0] w, input logic lng, input logic odd);
		logic p;
		p = lng ? ^w[7:0] : ^w[6:0];
		par_calc = p ^ odd;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Common timing.

	// The port stops while the processor is halted; the bus still answers but ignores writes.
	assign run = ~halt_mode;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bdiv_q <= 16'h0000;
		end else if (run && !cr1_q.disable_port) begin
			bdiv_q <= (bdiv_q >= baud_q) ? 16'h0000 : bdiv_q + 16'h0001;
		end
	end
	assign tick = run && !cr1_q.disable_port && (bdiv_q >= baud_q);

	// Two flip-flops bring the line into the clock domain.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_sync_q <= 2'h3;
		end else begin
			rx_sync_q <= {rx_sync_q[0], rx_pin};
		end
	end
	assign rxs = rx_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, answer registered.

	assign apb_do  = psel && penable && pready && run;
	assign wr_data = apb_do && pwrite && (paddr == uartm_pkg::OFS_DATA);
	assign rd_data = apb_do && !pwrite && (paddr == uartm_pkg::OFS_DATA);

	// Ready rises one cycle into the access phase and drops after it.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			case (paddr)
				uartm_pkg::OFS_DATA:   prdata <= {24'h000000, rdr_q};
				uartm_pkg::OFS_STATUS: prdata <= {24'h000000, !tdr_full_q, tc_q, rxf_q};
				uartm_pkg::OFS_CR1:    prdata <= {24'h000000, cr1_q};
				uartm_pkg::OFS_CR2:    prdata <= {24'h000000, cr2_q};
				uartm_pkg::OFS_BAUD:   prdata <= {16'h0000, baud_q};
				uartm_pkg::OFS_CR3:    prdata <= {31'h00000000, ovr_en_q};
				default: begin
					// Unmapped address answers zero with an error.
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// A status access arms the flag clearing sequence.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_seen_q <= 1'b0;
		end else if (apb_do) begin
			st_seen_q <= (paddr == uartm_pkg::OFS_STATUS);
		end
	end

	// Software writable configuration; the received ninth bit is hardware owned.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cr1_q    <= uartm_pkg::CR1_RST;
			baud_q   <= uartm_pkg::BAUD_RST;
			ovr_en_q <= 1'b0;
		end else begin
			if (apb_do && pwrite && paddr == uartm_pkg::OFS_CR1) begin
				cr1_q[6:0] <= pwdata[6:0];
			end
			if (apb_do && pwrite && paddr == uartm_pkg::OFS_BAUD) begin
				baud_q <= pwdata[15:0];
			end
			if (apb_do && pwrite && paddr == uartm_pkg::OFS_CR3) begin
				ovr_en_q <= pwdata[0];
			end
			// Ninth received bit is stored with each long word that ends while the data ready flag is clear, muted or not.
			if (frame_done && cr1_q.word_long && !rxf_q.rx_data_ready_flag) begin
				cr1_q.rx_bit8 <= rxw_q[8];
			end
		end
	end

	// Control two; hardware clears the mute request on a wake-up.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cr2_q <= uartm_pkg::CR2_RST;
		end else if (apb_do && pwrite && paddr == uartm_pkg::OFS_CR2) begin
			// A write in the wake cycle sets mute again, as software wrote.
			cr2_q <= pwdata[7:0];
		end else if (cr2_q.mute_request) begin
			if (idle_hit && !cr1_q.wake_addr_mark) begin
				cr2_q.mute_request <= 1'b0;
			end
			if (frame_done && cr1_q.wake_addr_mark && (cr1_q.word_long ?
			    (cr1_q.parity_enable ? rxw_q[7] : rxw_q[8]) :
			    (cr1_q.parity_enable ? rxw_q[6] : rxw_q[7]))) begin
				cr2_q.mute_request <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver sampling.

	assign snext     = scnt_q + 5'h01;
	assign bit_val   = maj3(maj_q);
	assign bit_noisy = !(maj_q[2] == maj_q[1] && maj_q[1] == rxs);

	// Frame completes when the stop bit's last sample is taken.
	assign frame_done = tick && rx_st_q == uartm_pkg::RX_STOP && snext == uartm_pkg::SMP_PER_BIT;

	// Idle frame: a whole frame time of ones while hunting.
	assign idle_hit = tick && rx_st_q == uartm_pkg::RX_HUNT && rxs && idle_arm_q &&
	                  idle_cnt_q == {cr1_q.word_long ? 4'hb : 4'ha, 4'h0} - 8'h01;

	// Line history gives the three samples before a falling edge.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hist_q <= 3'h7;
		end else if (tick) begin
			hist_q <= {hist_q[1:0], rxs};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_st_q <= uartm_pkg::RX_HUNT;
			scnt_q  <= 5'h00;
			maj_q   <= 3'h0;
			bidx_q  <= 4'h0;
			rxw_q   <= 9'h000;
		end else if (tick) begin
			case (rx_st_q)
				uartm_pkg::RX_HUNT: begin
					if (!rxs && cr2_q.rx_enable) begin
						scnt_q  <= 5'h01;
						rx_st_q <= uartm_pkg::RX_START;
					end
				end
				uartm_pkg::RX_START, uartm_pkg::RX_DATA, uartm_pkg::RX_STOP: begin
					scnt_q <= snext;
					if (snext == uartm_pkg::SMP_MAJ_A) begin
						maj_q[2] <= rxs;
					end
					if (snext == uartm_pkg::SMP_MAJ_B) begin
						maj_q[1] <= rxs;
					end
					if (snext == uartm_pkg::SMP_MAJ_C) begin
						maj_q[0] <= rxs;
					end
					if (snext == uartm_pkg::SMP_PER_BIT) begin
						scnt_q <= 5'h00;
						case (rx_st_q)
							uartm_pkg::RX_START: begin
								// A start whose majority is one is dropped.
								rx_st_q <= maj3(maj_q) ? uartm_pkg::RX_HUNT : uartm_pkg::RX_DATA;
								bidx_q  <= 4'h0;
								rxw_q   <= 9'h000;
							end
							uartm_pkg::RX_DATA: begin
								rxw_q[bidx_q] <= maj3(maj_q);
								bidx_q        <= bidx_q + 4'h1;
								if (bidx_q == (cr1_q.word_long ? 4'h8 : 4'h7)) begin
									rx_st_q <= uartm_pkg::RX_STOP;
								end
							end
							default: rx_st_q <= uartm_pkg::RX_HUNT;
						endcase
					end
				end
				default: rx_st_q <= uartm_pkg::RX_HUNT;
			endcase
		end
	end

	// Noise seen during the frame is held until that frame completes.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			npend_q <= 1'b0;
		end else if (frame_done) begin
			npend_q <= 1'b0;
		end else if (tick) begin
			case (rx_st_q)
				uartm_pkg::RX_HUNT: begin
					if (!rxs && cr2_q.rx_enable && hist_q != 3'h7) begin
						npend_q <= 1'b1;
					end
				end
				uartm_pkg::RX_START: begin
					if (rxs && (snext == uartm_pkg::SMP_EDGE_A || snext == uartm_pkg::SMP_EDGE_B ||
					            snext == uartm_pkg::SMP_EDGE_C)) begin
						npend_q <= 1'b1;
					end
					if (rxs && snext >= uartm_pkg::SMP_MAJ_A && snext <= uartm_pkg::SMP_MAJ_C) begin
						npend_q <= 1'b1;
					end
				end
				uartm_pkg::RX_DATA: begin
					if (snext == uartm_pkg::SMP_MAJ_C && bit_noisy) begin
						npend_q <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Ones counter for idle detection, rearmed by each word received while not muted.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_cnt_q <= 8'h00;
			idle_arm_q <= 1'b0;
		end else begin
			if (tick) begin
				idle_cnt_q <= (rx_st_q == uartm_pkg::RX_HUNT && rxs && !idle_hit) ?
				              idle_cnt_q + 8'h01 : 8'h00;
			end
			if (idle_hit) begin
				idle_arm_q <= 1'b0;
			end else if (frame_done && !cr2_q.mute_request) begin
				idle_arm_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive flags and data buffer.

	// Events set flags; a set in the clearing cycle wins.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxf_q <= 6'h00;
			rdr_q <= 8'h00;
		end else begin
			if (rd_data && st_seen_q) begin
				rxf_q <= 6'h00;
			end
			if (frame_done && (!cr2_q.mute_request || (cr1_q.wake_addr_mark &&
			    (cr1_q.word_long ? (cr1_q.parity_enable ? rxw_q[7] : rxw_q[8]) :
			                       (cr1_q.parity_enable ? rxw_q[6] : rxw_q[7]))))) begin
				if (rxf_q.rx_data_ready_flag && !(rd_data && st_seen_q)) begin
					// Buffer still full: only overrun is flagged, data kept.
					rxf_q.overrun_flag <= 1'b1;
				end else begin
					rdr_q                    <= rxw_q[7:0];
					rxf_q.rx_data_ready_flag <= 1'b1;
					// Stop bit noise is judged on its own middle samples.
					rxf_q.noise_flag         <= npend_q || (maj_q != 3'h0 && maj_q != 3'h7);
					rxf_q.framing_error_flag <= !bit_val;
					rxf_q.parity_error_flag  <= cr1_q.parity_enable &&
						(par_calc(rxw_q, cr1_q.word_long, cr1_q.parity_odd_select) !=
						 (cr1_q.word_long ? rxw_q[8] : rxw_q[7]));
				end
			end
			// idle flag not set on wake
			if (idle_hit && !cr2_q.mute_request) begin
				rxf_q.idle_flag <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmitter.

	// Buffer, shifter and complete flag.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tdr_q      <= 8'h00;
			tdr_full_q <= 1'b0;
			tc_q       <= 1'b1;
			tx_busy_q  <= 1'b0;
			tsh_q      <= 11'h7ff;
			tbits_q    <= 4'h0;
			tdiv_q     <= 4'h0;
			tx_pin     <= 1'b1;
		end else begin
			if (wr_data) begin
				tdr_q      <= pwdata[7:0];
				tdr_full_q <= 1'b1;
				if (st_seen_q) begin
					tc_q <= 1'b0;
				end
			end
			if (run && !tx_busy_q && tdr_full_q && cr2_q.tx_enable && !wr_data) begin
				tsh_q <= {2'h3, cr1_q.tx_bit8, tdr_q} << 1;
				if (cr1_q.parity_enable && cr1_q.word_long) begin
					tsh_q[9] <= par_calc({cr1_q.tx_bit8, tdr_q}, 1'b1, cr1_q.parity_odd_select);
				end
				if (cr1_q.parity_enable && !cr1_q.word_long) begin
					tsh_q[8] <= par_calc({cr1_q.tx_bit8, tdr_q}, 1'b0, cr1_q.parity_odd_select);
				end
				// A short frame puts its stop bit where the ninth bit would be.
				if (!cr1_q.word_long) begin
					tsh_q[9] <= 1'b1;
				end
				tsh_q[0]   <= 1'b0;
				tbits_q    <= cr1_q.word_long ? 4'hb : 4'ha;
				tdiv_q     <= 4'h0;
				tx_busy_q  <= 1'b1;
				tdr_full_q <= 1'b0;
			end else if (tick && tx_busy_q) begin
				tdiv_q <= tdiv_q + 4'h1;
				if (tdiv_q == 4'h0) begin
					tx_pin  <= tsh_q[0];
					tsh_q   <= {1'b1, tsh_q[10:1]};
					tbits_q <= tbits_q - 4'h1;
				end
				if (tdiv_q == 4'hf && tbits_q == 4'h0) begin
					tx_busy_q <= 1'b0;
					tc_q      <= 1'b1;
				end
			end
			if (!cr2_q.tx_enable && !tx_busy_q) begin
				tx_pin <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared interrupt.

	always_comb begin
		irq_d = (cr2_q.tx_empty_irq_enable && !tdr_full_q) ||
		        (cr2_q.tx_complete_irq_enable && tc_q);
		if (!cr2_q.mute_request) begin
			irq_d = irq_d ||
			        (cr2_q.rx_irq_enable && rxf_q.rx_data_ready_flag) ||
			        ((cr2_q.rx_irq_enable || ovr_en_q) && rxf_q.overrun_flag) ||
			        (cr2_q.quiet_line_irq_enable && rxf_q.idle_flag) ||
			        (cr1_q.parity_irq_enable && rxf_q.parity_error_flag);
		end
		irq_d = irq_d && !global_irq_mask;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq       <= 1'b0;
			wait_wake <= 1'b0;
		end else begin
			irq       <= irq_d && run;
			wait_wake <= irq_d && run && wait_mode;
		end
	end

endmodule

// [hdl/uartm_pkg.sv]
// Package with register map, field layouts, reset values and types of the serial port.
package uartm_pkg;

	// APB byte offsets of the registers.
	localparam logic [7:0] OFS_DATA   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CR1    = 8'h08;
	localparam logic [7:0] OFS_CR2    = 8'h0c;
	localparam logic [7:0] OFS_BAUD   = 8'h10;
	localparam logic [7:0] OFS_CR3    = 8'h14;

	// Reset values.
	localparam logic [7:0]  CR1_RST  = 8'h00;
	localparam logic [7:0]  CR2_RST  = 8'h00;
	localparam logic [15:0] BAUD_RST = 16'h0000;

	// Oversampling and sample numbers inside one bit.
	localparam logic [4:0] SMP_PER_BIT = 5'h10;
	localparam logic [4:0] SMP_MAJ_A   = 5'h08;
	localparam logic [4:0] SMP_MAJ_B   = 5'h09;
	localparam logic [4:0] SMP_MAJ_C   = 5'h0a;
	localparam logic [4:0] SMP_EDGE_A  = 5'h03;
	localparam logic [4:0] SMP_EDGE_B  = 5'h05;
	localparam logic [4:0] SMP_EDGE_C  = 5'h07;

	// Control register one, bit 7 down to bit 0.
	typedef struct packed {
		logic rx_bit8;
		logic tx_bit8;
		logic disable_port;
		logic word_long;
		logic wake_addr_mark;
		logic parity_enable;
		logic parity_odd_select;
		logic parity_irq_enable;
	} uartm_cr1_t;

	// Control register two, bit 7 down to bit 0.
	typedef struct packed {
		logic tx_empty_irq_enable;
		logic tx_complete_irq_enable;
		logic rx_irq_enable;
		logic quiet_line_irq_enable;
		logic tx_enable;
		logic rx_enable;
		logic mute_request;
		logic send_break;
	} uartm_cr2_t;

	// Receive status flags, bits 5 down to 0 of the status register.
	typedef struct packed {
		logic rx_data_ready_flag;
		logic idle_flag;
		logic overrun_flag;
		logic noise_flag;
		logic framing_error_flag;
		logic parity_error_flag;
	} uartm_rxflags_t;

	// Receiver sequencing states.
	typedef enum logic [1:0] {
		RX_HUNT,
		RX_START,
		RX_DATA,
		RX_STOP
	} uartm_rx_state_t;

endpackage

// [verif/uartm_core_assertions.sv]
// Concurrent checks on the serial port pins.
`timescale 1ns/1ps
module uartm_core_assertions (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        sys_rst,
	// Bus pins.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Line and processor pins.
	input wire logic        tx_pin,
	input wire logic        global_irq_mask,
	input wire logic        wait_mode,
	input wire logic        halt_mode,
	input wire logic        irq,
	input wire logic        wait_wake
);
	// One clock domain, so one default clock and reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// Interrupt gating and wake.
	property p_mask;
		$past(global_irq_mask) |-> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_wake_off;
		!$past(wait_mode) |-> !wait_wake;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake outside wait");
	property p_wake_on;
		wait_mode && $past(wait_mode) && irq && $past(irq) |-> wait_wake;
	endproperty
	a_wake_on: assert property (p_wake_on) else $error("no wake on irq");

	////////////////////////////////////////////////////////////////////////
	// Bus answer shape.
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_answer;
		psel && $rose(penable) |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	property p_err;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("bad error answer");

	////////////////////////////////////////////////////////////////////////
	// Line timing and halt freeze.
	property p_tx_start;
		$fell(tx_pin) |-> !tx_pin [*8] ##8 !tx_pin;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("short start bit");
	property p_halt;
		halt_mode && $past(halt_mode) |-> $stable(tx_pin);
	endproperty
	a_halt: assert property (p_halt) else $error("line moved in halt");

	// Main scenarios reached.
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_wake: cover property (wait_wake);
endmodule

bind uartm_core uartm_core_assertions u_chk (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_pin(tx_pin),
	.global_irq_mask(global_irq_mask), .wait_mode(wait_mode),
	.halt_mode(halt_mode), .irq(irq), .wait_wake(wait_wake)
);

// [verif/uartm_node_model.sv]
// Behavioural serial node on the far end of the line.
`timescale 1ns/1ps
module uartm_node_model (
	// Clock pacing the bits.
	input  wire logic clk,
	// Line towards the port and line from it.
	output logic      line_out,
	input  wire logic line_in
);
	// The line rests high between frames, as with a pull-up.
	initial line_out = 1'b1;

	// Sends start, n bits LSB first, stop; bit nz gets a one-sample glitch.
	// frame layout
	task automatic send(input logic [8:0] d, input int n, input int nz);
		logic [10:0] f;
		f = 11'h7ff;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++) f[i + 1] = d[i];
		for (int j = 0; j < n + 2; j++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge clk);
				line_out <= (j == nz && c == 8) ? ~f[j] : f[j];
			end
		end
		repeat (6) @(posedge clk);
	endtask

	// Waits for a start bit, then samples n bits at their middle.
	task automatic recv(input int n, output logic [8:0] d);
		int t;
		t = 0;
		d = 9'h000;
		while (line_in !== 1'b0 && t < 3000) begin
			@(posedge clk);
			t++;
		end
		repeat (8) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (16) @(posedge clk);
			d[i] = line_in;
		end
	endtask
endmodule

// [verif/uartm_core_tb.sv]
// Self-checking bench for the serial port.
`timescale 1ns/1ps
module uartm_core_tb;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic        rx_pin, tx_pin, global_irq_mask, wait_mode, halt_mode;
	logic        irq, wait_wake, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0]  d;
	int          num_errors, check_count, cyc;

	// Far node and the port under test.
	uartm_node_model node (.clk(clk), .line_out(rx_pin), .line_in(tx_pin));
	uartm_core uut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.global_irq_mask(global_irq_mask), .wait_mode(wait_mode),
		.halt_mode(halt_mode), .irq(irq), .wait_wake(wait_wake)
	);

	// 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Hang guard: a cycle ceiling well above the expected run.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks.
	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_regs();
		apb(0, uartm_pkg::OFS_STATUS, 0);
		chk(rd, 32'hc0);
		apb(0, 8'h20, 0);
		chk({31'h0, er}, 32'h1);
	endtask

	// Sent parity replaces the data MSB, for both senses.
	task automatic t_tx_parity();
		apb(1, uartm_pkg::OFS_CR2, 32'h08);
		for (int p = 0; p < 2; p++) begin
			apb(1, uartm_pkg::OFS_CR1, {29'h0, 1'b1, p[0], 1'b0});
			apb(1, uartm_pkg::OFS_DATA, 32'h35);
			node.recv(8, d);
			chk({23'h0, d}, {24'h0, p[0] ^ (^7'h35), 7'h35});
			repeat (20) @(posedge clk);
		end
	endtask

	// Received parity, good and bad, in both senses.
	task automatic t_rx_parity();
		logic par;
		apb(1, uartm_pkg::OFS_CR2, 32'h04);
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 2; b++) begin
				par = (^7'h35) ^ p[0] ^ b[0];
				apb(1, uartm_pkg::OFS_CR1, {29'h0, 1'b1, p[0], 1'b1});
				node.send({1'b0, par, 7'h35}, 8, 99);
				apb(0, uartm_pkg::OFS_STATUS, 0);
				chk(rd & 32'h21, b ? 32'h21 : 32'h20);
				chk({31'h0, irq}, {31'h0, b[0]});
				apb(0, uartm_pkg::OFS_DATA, 0);
			end
		end
	endtask

	// A glitch in the start bit, then in a data bit.
	task automatic t_noise();
		apb(1, uartm_pkg::OFS_CR1, 32'h00);
		for (int k = 0; k < 2; k++) begin
			node.send(9'h05a, 8, k * 4);
			apb(0, uartm_pkg::OFS_STATUS, 0);
			chk(rd & 32'h24, 32'h24);
			apb(0, uartm_pkg::OFS_DATA, 0);
			chk(rd, 32'h5a);
		end
	endtask

	// Address-mark wake; control two is only read after the wake.
	// no muted writes
	task automatic t_mute_addr();
		apb(1, uartm_pkg::OFS_CR1, 32'h0c);
		apb(1, uartm_pkg::OFS_CR2, 32'h26);
		node.send(9'h0b1, 8, 99);
		apb(0, uartm_pkg::OFS_STATUS, 0);
		chk(rd & 32'h3f, 32'h0);
		chk({31'h0, irq}, 32'h0);
		node.send(9'h053, 8, 99);
		chk({31'h0, irq}, 32'h1);
		apb(0, uartm_pkg::OFS_CR2, 0);
		chk(rd, 32'h24);
		apb(0, uartm_pkg::OFS_STATUS, 0);
		apb(0, uartm_pkg::OFS_DATA, 0);
		chk(rd & 32'h7f, 32'h53);
	endtask

	// Idle-line wake leaves the idle flag clear.
	task automatic t_mute_idle();
		apb(1, uartm_pkg::OFS_CR1, 32'h00);
		apb(1, uartm_pkg::OFS_CR2, 32'h04);
		node.send(9'h041, 8, 99);
		apb(0, uartm_pkg::OFS_STATUS, 0);
		apb(0, uartm_pkg::OFS_DATA, 0);
		apb(1, uartm_pkg::OFS_CR2, 32'h06);
		repeat (250) @(posedge clk);
		apb(0, uartm_pkg::OFS_CR2, 0);
		chk(rd, 32'h04);
		apb(0, uartm_pkg::OFS_STATUS, 0);
		chk(rd & 32'h10, 32'h0);
	endtask

	// Transmit events against their enables, mask and wait.
	task automatic t_irq();
		for (int k = 0; k < 2; k++) begin
			apb(1, uartm_pkg::OFS_CR2, k ? 32'h40 : 32'h80);
			repeat (3) @(posedge clk);
			chk({31'h0, irq}, 32'h1);
			global_irq_mask <= 1'b1;
			repeat (3) @(posedge clk);
			chk({31'h0, irq}, 32'h0);
			global_irq_mask <= 1'b0;
			wait_mode <= 1'b1;
			repeat (3) @(posedge clk);
			chk({31'h0, wait_wake}, 32'h1);
			wait_mode <= 1'b0;
		end
		apb(1, uartm_pkg::OFS_CR2, 32'h00);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask

	// Halt in mid frame freezes registers and the line.
	task automatic t_halt();
		apb(1, uartm_pkg::OFS_CR2, 32'h08);
		apb(1, uartm_pkg::OFS_DATA, 32'h55);
		repeat (40) @(posedge clk);
		halt_mode <= 1'b1;
		apb(1, uartm_pkg::OFS_DATA, 32'h0f);
		apb(1, uartm_pkg::OFS_CR2, 32'h00);
		apb(0, uartm_pkg::OFS_CR2, 0);
		chk(rd, 32'h08);
		repeat (100) @(posedge clk);
		// Halt fell inside data bit one of 55, which is zero.
		chk({31'h0, tx_pin}, 32'h0);
		halt_mode <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, global_irq_mask, wait_mode, halt_mode} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_tx_parity();
		t_rx_parity();
		t_noise();
		t_mute_addr();
		t_mute_idle();
		t_irq();
		t_halt();
		results();
	end
endmodule
